/* design/command_host_fifo_control.sv */
// Notes on behaviour
// - Command bit 7 written 1 puts the whole device into power-down.
// - Command bit 6 written 1 powers down receiver and transmitter.
// - Command bits 4..0 hold the running command; writing them starts or stops it.
// - While unlock is 1 the grant bits may change; the next write clears unlock.
// - Host grant bit 6 hands the shared bus to the host interface.
// - Secure grant bit 5 hands the shared bus to the secure module interface.
// - Both grant bits are never 1 together.
// - A grant bit takes a 1 only after an earlier unlock write by the host.
// - Select field bits 3..2: 0 off, 1 SPI, 2 low-speed two-wire, 3 two-wire.
// - Capacity bit 7: 1 gives 255 bytes, 0 gives 512 bytes.
// - High alert reads 1 when capacity minus count is at most the level.
// - Low alert reads 1 when the count is at most the level.
// - Flush bit 4 written 1 empties the buffer; it always reads 0.
// - Control bit 2 is level bit 8, used only in 512-byte mode.
// - Control bits 1..0 are count bits 9..8, meaningful in 512-byte mode.
// - Alert level register is a read/write byte, low bits of the threshold.
// - Fill count register reads count bits 7..0 and resets to zero.
// - Data port write adds one to the count; a read subtracts one.
// - Data port accesses leave the address pointer unchanged; others advance it.
`timescale 1ns/1ps
`include "command_host_fifo_control_consts.svh"

module command_host_fifo_control
  import command_host_fifo_control_pkg::*;
#(
  parameter int DEPTH_LARGE = 512,
  parameter int DEPTH_SMALL = 255
) (
  // Clock and reset.
  input  wire logic      ref_clk,
  input  wire logic      sys_rst,
  // Register access from the host interface.
  input  wire logic      ptr_load,
  input  wire reg_addr_t ptr_value,
  input  wire logic      acc_wr,
  input  wire logic      acc_rd,
  input  wire reg_byte_t wr_data,
  output reg_addr_t      cur_addr,
  output reg_byte_t      rd_data,
  output logic           rd_valid,
  // Modem side of the buffer.
  input  wire logic      modem_push,
  input  wire reg_byte_t modem_push_data,
  input  wire logic      modem_pop,
  output reg_byte_t      modem_pop_data,
  output logic           modem_pop_valid,
  // Command engine.
  input  wire logic      cmd_done,
  input  wire logic      wake_up,
  output logic [4:0]     command,
  output logic           command_start,
  output logic           standby,
  output logic           radio_power_down,
  // Bus ownership.
  output logic           host_bus_grant,
  output logic           secure_module_bus_grant,
  output sam_if_t        secure_module_if_select,
  // Buffer status.
  output logic [9:0]     fill_count,
  output logic           high_alert_flag,
  output logic           low_alert_flag
);

  logic [7:0] mem [0:DEPTH_LARGE-1];

  logic       unlock_bit;
  logic       buffer_capacity_select;
  logic       level_bit8;
  reg_byte_t  alert_level;
  logic [8:0] wr_ptr;
  logic [8:0] rd_ptr;

  // Register decode.
  wire acc_any    = acc_wr | acc_rd;
  wire wr_cmd     = acc_wr && cur_addr == `ADDR_COMMAND;
  wire wr_own     = acc_wr && cur_addr == `ADDR_BUS_OWNER;
  wire wr_bctl    = acc_wr && cur_addr == `ADDR_BUF_CONTROL;
  wire wr_level   = acc_wr && cur_addr == `ADDR_ALERT_LEVEL;
  wire wr_port    = acc_wr && cur_addr == `ADDR_DATA_PORT;
  wire rd_port    = !acc_wr && acc_rd && cur_addr == `ADDR_DATA_PORT;
  wire on_port    = cur_addr == `ADDR_DATA_PORT;
  wire flush      = wr_bctl && wr_data[`BCTL_FLUSH_BIT];

  // Capacity and occupancy.
  wire [9:0] capacity   = buffer_capacity_select ? 10'(DEPTH_SMALL) : 10'(DEPTH_LARGE);
  wire [8:0] last_slot  = 9'(capacity - 10'h001);
  wire       buf_full   = fill_count >= capacity;
  wire       buf_empty  = fill_count == `RST_COUNT;
  wire       push_host  = wr_port && !buf_full;
  wire       push_modem = modem_push && !wr_port && !buf_full;
  wire       do_push    = !flush && (push_host || push_modem);
  wire       pop_host   = rd_port && !buf_empty;
  wire       pop_modem  = modem_pop && !rd_port && !buf_empty;
  wire       do_pop     = !flush && (pop_host || pop_modem);
  wire [7:0] push_byte  = wr_port ? wr_data : modem_push_data;
  wire [7:0] head_byte  = mem[rd_ptr];
  wire [8:0] wr_ptr_inc = (wr_ptr >= last_slot) ? `RST_PTR : wr_ptr + 9'h001;
  wire [8:0] rd_ptr_inc = (rd_ptr >= last_slot) ? `RST_PTR : rd_ptr + 9'h001;

  wire [9:0] next_fill_count = flush ? `RST_COUNT :
                               fill_count + {9'h000, do_push} - {9'h000, do_pop};

  // Threshold: level bit 8 only counts in 512-byte mode.
  wire [9:0] threshold = {1'b0, level_bit8 & ~buffer_capacity_select, alert_level};
  wire [9:0] room      = capacity - fill_count;
  wire       next_high = room <= threshold;
  wire       next_low  = fill_count <= threshold;

  // Ownership write: grants move only while unlocked and never both set.
  wire       own_grant_ok    = wr_own && unlock_bit &&
                               !(wr_data[`OWN_HOST_BIT] && wr_data[`OWN_SECURE_BIT]);
  wire [4:0] next_command    = wr_cmd ? wr_data[`CMD_CODE_MSB:0] :
                               (cmd_done ? `CMD_IDLE : command);

  // Read multiplexer; reserved bits and unmapped addresses read zero.
  wire [7:0] rd_cmd  = {standby, radio_power_down, 1'b0, command};
  wire [7:0] rd_own  = {unlock_bit, host_bus_grant, secure_module_bus_grant, 1'b0,
                        secure_module_if_select, 2'h0};
  wire [7:0] rd_bctl = {buffer_capacity_select, high_alert_flag, low_alert_flag, 1'b0,
                        1'b0, level_bit8, fill_count[9:8]};
  wire [7:0] rd_mux  = (cur_addr == `ADDR_COMMAND)     ? rd_cmd :
                       (cur_addr == `ADDR_BUS_OWNER)   ? rd_own :
                       (cur_addr == `ADDR_BUF_CONTROL) ? rd_bctl :
                       (cur_addr == `ADDR_ALERT_LEVEL) ? alert_level :
                       (cur_addr == `ADDR_FILL_COUNT)  ? fill_count[7:0] :
                       (on_port && !buf_empty)         ? head_byte : `RST_BYTE;

  wire [6:0] next_addr = ptr_load ? ptr_value :
                         (acc_any && !on_port) ? cur_addr + 7'h01 : cur_addr;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur_addr <= `ADDR_COMMAND;
      rd_data  <= `RST_BYTE;
      rd_valid <= 1'b0;
    end else begin
      cur_addr <= next_addr;
      rd_data  <= (acc_rd && !acc_wr) ? rd_mux : rd_data;
      rd_valid <= acc_rd && !acc_wr;
    end
  end

  // Command register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      standby          <= 1'b0;
      radio_power_down <= 1'b0;
      command          <= `CMD_IDLE;
      command_start    <= 1'b0;
    end else begin
      standby          <= wr_cmd ? wr_data[`CMD_STANDBY_BIT] : (standby & ~wake_up);
      radio_power_down <= wr_cmd ? wr_data[`CMD_RADIO_PD_BIT] : radio_power_down;
      command          <= next_command;
      command_start    <= wr_cmd;
    end
  end

  // Bus ownership register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      unlock_bit              <= 1'b0;
      host_bus_grant          <= 1'b0;
      secure_module_bus_grant <= 1'b0;
      secure_module_if_select <= sam_if_off;
    end else begin
      if (wr_own) begin
        unlock_bit              <= unlock_bit ? 1'b0 : wr_data[`OWN_UNLOCK_BIT];
        secure_module_if_select <= sam_if_t'(wr_data[`OWN_SEL_MSB:`OWN_SEL_LSB]);
      end
      if (own_grant_ok) begin
        host_bus_grant          <= wr_data[`OWN_HOST_BIT];
        secure_module_bus_grant <= wr_data[`OWN_SECURE_BIT];
      end
    end
  end

  // Buffer configuration and occupancy.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      buffer_capacity_select <= 1'b0;
      level_bit8             <= 1'b0;
      alert_level            <= `RST_BYTE;
      fill_count             <= `RST_COUNT;
      wr_ptr                 <= `RST_PTR;
      rd_ptr                 <= `RST_PTR;
      high_alert_flag        <= 1'b0;
      low_alert_flag         <= 1'b1;
    end else begin
      if (wr_bctl) begin
        buffer_capacity_select <= wr_data[`BCTL_SIZE_BIT];
        level_bit8             <= wr_data[`BCTL_LEVEL8_BIT];
      end
      alert_level     <= wr_level ? wr_data : alert_level;
      fill_count      <= next_fill_count;
      wr_ptr          <= flush ? `RST_PTR : (do_push ? wr_ptr_inc : wr_ptr);
      rd_ptr          <= flush ? `RST_PTR : (do_pop ? rd_ptr_inc : rd_ptr);
      high_alert_flag <= next_high;
      low_alert_flag  <= next_low;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      modem_pop_data  <= `RST_BYTE;
      modem_pop_valid <= 1'b0;
    end else begin
      modem_pop_data  <= (do_pop && pop_modem) ? head_byte : modem_pop_data;
      modem_pop_valid <= do_pop && pop_modem;
    end
  end

  // Checks.
  sequence s_unlock_write;
    wr_own && !unlock_bit && wr_data[`OWN_UNLOCK_BIT];
  endsequence

  sequence s_unlocked_grant;
    wr_own && unlock_bit && wr_data[`OWN_HOST_BIT] && !wr_data[`OWN_SECURE_BIT];
  endsequence

  property p_standby_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_cmd |=> standby == $past(wr_data[`CMD_STANDBY_BIT]);
  endproperty
  a_standby_write: assert property (p_standby_write)
    else $error("standby does not follow command write");

  property p_radio_pd;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_cmd |=> radio_power_down == $past(wr_data[`CMD_RADIO_PD_BIT]);
  endproperty
  a_radio_pd: assert property (p_radio_pd)
    else $error("radio power down does not follow command write");

  property p_command_code;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_cmd |=> command == $past(wr_data[4:0]) && command_start;
  endproperty
  a_command_code: assert property (p_command_code)
    else $error("command code not taken from write");

  property p_command_idle;
    @(posedge ref_clk) disable iff (sys_rst)
      cmd_done && !wr_cmd |=> command == `CMD_IDLE;
  endproperty
  a_command_idle: assert property (p_command_idle)
    else $error("command code not returned to idle");

  property p_unlock_sets;
    @(posedge ref_clk) disable iff (sys_rst)
      s_unlock_write |=> unlock_bit;
  endproperty
  a_unlock_sets: assert property (p_unlock_sets)
    else $error("unlock bit not set by unlock write");

  property p_unlock_clears;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_own && unlock_bit |=> !unlock_bit;
  endproperty
  a_unlock_clears: assert property (p_unlock_clears)
    else $error("unlock bit not cleared by following write");

  property p_grant_after_unlock;
    @(posedge ref_clk) disable iff (sys_rst)
      s_unlocked_grant |=> host_bus_grant && !secure_module_bus_grant;
  endproperty
  a_grant_after_unlock: assert property (p_grant_after_unlock)
    else $error("host grant not given after unlock");

  property p_grant_locked;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(host_bus_grant) || $rose(secure_module_bus_grant) |-> $past(unlock_bit);
  endproperty
  a_grant_locked: assert property (p_grant_locked)
    else $error("grant set without prior unlock");

  property p_grant_exclusive;
    @(posedge ref_clk) disable iff (sys_rst)
      !(host_bus_grant && secure_module_bus_grant);
  endproperty
  a_grant_exclusive: assert property (p_grant_exclusive)
    else $error("both bus grants set");

  property p_flush_empties;
    @(posedge ref_clk) disable iff (sys_rst)
      flush |=> fill_count == `RST_COUNT ##1 low_alert_flag;
  endproperty
  a_flush_empties: assert property (p_flush_empties)
    else $error("flush did not empty buffer");

  property p_count_step;
    @(posedge ref_clk) disable iff (sys_rst)
      push_host && !flush && !modem_pop |=> fill_count == $past(fill_count) + 10'h001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("fill count did not rise on port write");

  property p_pop_count;
    @(posedge ref_clk) disable iff (sys_rst)
      pop_host && !flush && !modem_push |=> fill_count == $past(fill_count) - 10'h001;
  endproperty
  a_pop_count: assert property (p_pop_count)
    else $error("fill count did not fall on port read");

  property p_fill_reg_read;
    @(posedge ref_clk) disable iff (sys_rst)
      acc_rd && !acc_wr && cur_addr == `ADDR_FILL_COUNT |=> rd_data == $past(fill_count[7:0]);
  endproperty
  a_fill_reg_read: assert property (p_fill_reg_read)
    else $error("fill count register read wrong");

  property p_ctrl_count_bits;
    @(posedge ref_clk) disable iff (sys_rst)
      acc_rd && !acc_wr && cur_addr == `ADDR_BUF_CONTROL |=>
        rd_data[`BCTL_COUNT_MSB:0] == $past(fill_count[9:8]);
  endproperty
  a_ctrl_count_bits: assert property (p_ctrl_count_bits)
    else $error("control register count bits wrong");

  property p_port_ptr_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      acc_any && on_port && !ptr_load |=> $stable(cur_addr);
  endproperty
  a_port_ptr_hold: assert property (p_port_ptr_hold)
    else $error("address moved on data port access");

  property p_low_alert;
    @(posedge ref_clk) disable iff (sys_rst)
      ##1 low_alert_flag == ($past(fill_count) <= $past(threshold));
  endproperty
  a_low_alert: assert property (p_low_alert)
    else $error("low alert wrong");

  property p_high_alert;
    @(posedge ref_clk) disable iff (sys_rst)
      ##1 high_alert_flag == ($past(room) <= $past(threshold));
  endproperty
  a_high_alert: assert property (p_high_alert)
    else $error("high alert wrong");

  property p_flush_reads_zero;
    @(posedge ref_clk) disable iff (sys_rst)
      acc_rd && !acc_wr && cur_addr == `ADDR_BUF_CONTROL |=> !rd_data[`BCTL_FLUSH_BIT];
  endproperty
  a_flush_reads_zero: assert property (p_flush_reads_zero)
    else $error("flush bit read as one");

endmodule

/* design/command_host_fifo_control_consts.svh */
`ifndef COMMAND_HOST_FIFO_CONTROL_CONSTS_SVH
`define COMMAND_HOST_FIFO_CONTROL_CONSTS_SVH

`define ADDR_COMMAND      7'h00
`define ADDR_BUS_OWNER    7'h01
`define ADDR_BUF_CONTROL  7'h02
`define ADDR_ALERT_LEVEL  7'h03
`define ADDR_FILL_COUNT   7'h04
`define ADDR_DATA_PORT    7'h05

`define CMD_STANDBY_BIT   7
`define CMD_RADIO_PD_BIT  6
`define CMD_CODE_MSB      4
`define CMD_IDLE          5'h00

`define OWN_UNLOCK_BIT    7
`define OWN_HOST_BIT      6
`define OWN_SECURE_BIT    5
`define OWN_SEL_MSB       3
`define OWN_SEL_LSB       2

`define BCTL_SIZE_BIT     7
`define BCTL_HIGH_BIT     6
`define BCTL_LOW_BIT      5
`define BCTL_FLUSH_BIT    4
`define BCTL_LEVEL8_BIT   2
`define BCTL_COUNT_MSB    1

`define RST_BYTE          8'h00
`define RST_COUNT         10'h000
`define RST_PTR           9'h000

`endif

/* design/command_host_fifo_control_pkg.sv */
package command_host_fifo_control_pkg;

  typedef logic [6:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    sam_if_off = 2'h0,
    sam_if_spi = 2'h1,
    sam_if_low = 2'h2,
    sam_if_std = 2'h3
  } sam_if_t;

endpackage

/* tb/host_model.sv */
`timescale 1ns/1ps
module host_model import command_host_fifo_control_pkg::*; (
  // Clock.
  input  wire logic      ref_clk,
  // Register access toward the device.
  output logic           ptr_load,
  output reg_addr_t      ptr_value,
  output logic           acc_wr,
  output logic           acc_rd,
  output reg_byte_t      wr_data,
  // Read answer.
  input  wire reg_byte_t rd_data,
  input  wire logic      rd_valid
);
  initial begin
    ptr_load = 1'b0;
    ptr_value = 7'h00;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    wr_data = 8'h00;
  end

  // One access, optionally after a pointer load; idle wr_data, and ptr_value after a load, never keep their last value.
  task automatic acc(input logic ld, input reg_addr_t a, input logic w, input reg_byte_t d,
                     output reg_byte_t q);
    @(posedge ref_clk);
    #1;
    if (ld) begin
      ptr_load = 1'b1;
      ptr_value = a;
      @(posedge ref_clk);
      #1;
      ptr_load = 1'b0;
      ptr_value = ~a;
    end
    acc_wr = w;
    acc_rd = !w;
    wr_data = w ? d : ~wr_data;
    @(posedge ref_clk);
    #1;
    q = (rd_valid === 1'b1) ? rd_data : ~rd_data;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    wr_data = ~wr_data;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`include "command_host_fifo_control_consts.svh"
module tb import command_host_fifo_control_pkg::*;;
  logic       ref_clk, sys_rst, ptr_load, acc_wr, acc_rd, modem_push, modem_pop;
  logic       cmd_done, wake_up, rd_valid, modem_pop_valid, command_start, standby;
  logic       radio_power_down, host_bus_grant, secure_module_bus_grant;
  logic       high_alert_flag, low_alert_flag;
  logic [4:0] command;
  logic [9:0] fill_count;
  reg_addr_t  ptr_value, cur_addr;
  reg_byte_t  wr_data, rd_data, modem_push_data, modem_pop_data, q;
  sam_if_t    secure_module_if_select;
  int         err_count, comparisons;

  command_host_fifo_control DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .ptr_load(ptr_load),
    .ptr_value(ptr_value), .acc_wr(acc_wr), .acc_rd(acc_rd), .wr_data(wr_data),
    .cur_addr(cur_addr), .rd_data(rd_data), .rd_valid(rd_valid), .modem_push(modem_push),
    .modem_push_data(modem_push_data), .modem_pop(modem_pop), .modem_pop_data(modem_pop_data),
    .modem_pop_valid(modem_pop_valid), .cmd_done(cmd_done), .wake_up(wake_up),
    .command(command), .command_start(command_start), .standby(standby),
    .radio_power_down(radio_power_down), .host_bus_grant(host_bus_grant),
    .secure_module_bus_grant(secure_module_bus_grant),
    .secure_module_if_select(secure_module_if_select), .fill_count(fill_count),
    .high_alert_flag(high_alert_flag), .low_alert_flag(low_alert_flag));

  host_model host (.ref_clk(ref_clk), .ptr_load(ptr_load), .ptr_value(ptr_value),
    .acc_wr(acc_wr), .acc_rd(acc_rd), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  task automatic finish_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    host.acc(1'b1, a, 1'b1, d, q);
  endtask

  task automatic rd(input reg_addr_t a, input reg_byte_t e, input string n);
    host.acc(1'b1, a, 1'b0, 8'h00, q);
    chk(n, {2'b00, e}, {2'b00, q});
  endtask

  // Alerts follow the count one edge later.
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic push_n(input int n);
    @(posedge ref_clk);
    #1;
    modem_push = 1'b1;
    repeat (n) @(posedge ref_clk);
    #1;
    modem_push = 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    err_count++;
    finish_test;
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    modem_push = 1'b0;
    modem_push_data = 8'h3C;
    modem_pop = 1'b0;
    cmd_done = 1'b0;
    wake_up = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    chk("low_alert_rst", 10'h001, {9'h000, low_alert_flag});
    rd(`ADDR_FILL_COUNT, 8'h00, "fill_reg_rst");
    rd(`ADDR_BUF_CONTROL, 8'h20, "ctrl_rst");
    chk("ptr_inc", {3'h0, `ADDR_ALERT_LEVEL}, {3'h0, cur_addr});
    rd(7'h10, 8'h00, "unmapped");
    wr(`ADDR_COMMAND, 8'hC3);
    chk("standby", 10'h001, {9'h000, standby});
    chk("radio_pd", 10'h001, {9'h000, radio_power_down});
    chk("command", 10'h003, {5'h00, command});
    chk("cmd_start", 10'h001, {9'h000, command_start});
    @(posedge ref_clk);
    #1;
    cmd_done = 1'b1;
    wake_up = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_done = 1'b0;
    wake_up = 1'b0;
    chk("cmd_end", 10'h000, {5'h00, command});
    chk("wake", 10'h000, {9'h000, standby});
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_BUS_OWNER, {4'h4, s[1:0], 2'b00});
      chk("select", 10'(s), {8'h00, secure_module_if_select});
      chk("locked_host", 10'h000, {9'h000, host_bus_grant});
    end
    wr(`ADDR_BUS_OWNER, 8'h80);
    wr(`ADDR_BUS_OWNER, 8'h40);
    chk("host_grant", 10'h001, {9'h000, host_bus_grant});
    wr(`ADDR_BUS_OWNER, 8'h20);
    chk("relocked", 10'h002, {8'h00, host_bus_grant, secure_module_bus_grant});
    wr(`ADDR_BUS_OWNER, 8'h80);
    wr(`ADDR_BUS_OWNER, 8'h60);
    chk("both_refused", 10'h002, {8'h00, host_bus_grant, secure_module_bus_grant});
    wr(`ADDR_BUS_OWNER, 8'h80);
    wr(`ADDR_BUS_OWNER, 8'h20);
    chk("secure_grant", 10'h001, {8'h00, host_bus_grant, secure_module_bus_grant});
    wr(`ADDR_ALERT_LEVEL, 8'h02);
    rd(`ADDR_ALERT_LEVEL, 8'h02, "level");
    wr(`ADDR_FILL_COUNT, 8'h55);
    wr(`ADDR_BUF_CONTROL, 8'h80);
    for (int i = 0; i < 3; i++) begin
      host.acc(i == 0, `ADDR_DATA_PORT, 1'b1, 8'hA5 + 8'(i), q);
    end
    chk("port_ptr", 10'h005, {3'h0, cur_addr});
    chk("fill_push", 10'h003, fill_count);
    settle;
    rd(`ADDR_BUF_CONTROL, 8'h80, "ctrl_255");
    rd(`ADDR_FILL_COUNT, 8'h03, "fill_reg");
    host.acc(1'b1, `ADDR_DATA_PORT, 1'b0, 8'h00, q);
    chk("pop_data", 10'h0A5, {2'b00, q});
    chk("fill_pop", 10'h002, fill_count);
    chk("port_ptr_rd", 10'h005, {3'h0, cur_addr});
    @(posedge ref_clk);
    #1;
    modem_pop = 1'b1;
    @(posedge ref_clk);
    #1;
    modem_pop = 1'b0;
    chk("modem_pop", 10'h1A6, {1'b0, modem_pop_valid, modem_pop_data});
    push_n(251);
    settle;
    chk("hi_below", 10'h000, {9'h000, high_alert_flag});
    push_n(1);
    settle;
    chk("hi_at", 10'h001, {9'h000, high_alert_flag});
    push_n(5);
    chk("full_255", 10'd255, fill_count);
    wr(`ADDR_BUF_CONTROL, 8'h90);
    chk("flush", 10'h000, fill_count);
    settle;
    chk("alerts_flush", 10'h001, {8'h00, high_alert_flag, low_alert_flag});
    rd(`ADDR_BUF_CONTROL, 8'hA0, "flush_reads_0");
    wr(`ADDR_BUF_CONTROL, 8'h04);
    push_n(300);
    chk("fill_512", 10'd300, fill_count);
    settle;
    rd(`ADDR_BUF_CONTROL, 8'h45, "ctrl_512");
    rd(`ADDR_FILL_COUNT, 8'h2C, "fill_reg_512");
    finish_test;
  end
endmodule
